/* File: flag_ctl.v */
// Summary of operation
// - flags are active low: write zero to request, one to release
// - the host lifts output enable between polling reads
// - the host writes zero first, then reads back
// - after a failed claim the host polls or withdraws with a one
// - at start-up the host writes one to every flag
`timescale 1ns/1ps
`include "flag_ctl_defs.vh"
module flag_ctl #(
   parameter ACCESS_CYC = `ACCESS_CYC,
   parameter RECOVER_CYC = `RECOVER_CYC,
   parameter ADDR_W = 13
)(
   input wire ref_clk,
   input wire resetn,
   input wire cmd_valid,
   output wire cmd_ready,
   input wire [1:0] cmd_op,
   input wire [2:0] cmd_index,
   output reg done_q,
   output reg granted_q,
   output reg init_busy_q,
   output reg flag_space_select_n,
   output reg mem_select_n,
   output reg read_write_n,
   output reg output_enable_n,
   output reg [ADDR_W-1:0] addr,
   output reg [7:0] data_out,
   output reg data_oe,
   input wire [7:0] data_in
);
   localparam S_INIT = 6'h01;
   localparam S_IDLE = 6'h02;
   localparam S_WRITE = 6'h04;
   localparam S_GAP = 6'h08;
   localparam S_READ = 6'h10;
   localparam S_DONE = 6'h20;
   // every write strobe is followed by a recovery gap with both selects high
   reg [5:0] state_q;
   reg [1:0] op_q;
   reg [2:0] idx_q;
   // access and recovery share one 8-bit counter; a read loads the access count plus two, so the access count must stay below 254
   reg [7:0] cnt_q;
   reg [7:0] sync1_q;
   reg [7:0] sync2_q;
   wire cnt_zero = (cnt_q == 8'h00);
   wire read_bit = sync2_q[0];
   // commands are only taken in idle; one offered earlier simply waits its turn
   assign cmd_ready = (state_q == S_IDLE);
   // the far side answers without our clock, so its data passes two stages first
   always @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         sync1_q <= 8'h00;
         sync2_q <= 8'h00;
      end
      else
      begin
         sync1_q <= data_in;
         sync2_q <= sync1_q;
      end
   end
   always @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         state_q <= S_INIT;
         op_q <= `CMD_INIT;
         idx_q <= 3'h0;
         cnt_q <= 8'h00;
         done_q <= 1'b0;
         granted_q <= 1'b0;
         init_busy_q <= 1'b1;
         flag_space_select_n <= 1'b1;
         // memory space is never touched: this block only works in flag space
         mem_select_n <= 1'b1;
         read_write_n <= 1'b1;
         output_enable_n <= 1'b1;
         addr <= {ADDR_W{1'b0}};
         data_out <= 8'hff;
         data_oe <= 1'b0;
      end
      else
      begin
         done_q <= 1'b0;
         case (state_q)
            S_INIT:
            begin
               // one release per flag before any command is served
               // this sweep frees our side only; the far side must sweep its own latches
               op_q <= `CMD_INIT;
               state_q <= S_WRITE;
               cnt_q <= ACCESS_CYC[7:0];
               flag_space_select_n <= 1'b0;
               read_write_n <= 1'b0;
               addr <= {{(ADDR_W-3){1'b0}}, idx_q};
               data_out <= 8'hff;
               data_oe <= 1'b1;
            end
            S_IDLE:
            begin
               if (cmd_valid)
               begin
                  op_q <= cmd_op;
                  idx_q <= cmd_index;
                  // upper address bits stay zero since flag space ignores them
                  addr <= {{(ADDR_W-3){1'b0}}, cmd_index};
                  flag_space_select_n <= 1'b0;
                  cnt_q <= ACCESS_CYC[7:0];
                  if (cmd_op == `CMD_POLL)
                  begin
                     // a poll must also wait out the two synchroniser stages
                     cnt_q <= ACCESS_CYC[7:0] + 8'h02;
                     state_q <= S_READ;
                     output_enable_n <= 1'b0;
                  end
                  else if (cmd_op == `CMD_INIT)
                  begin
                     idx_q <= 3'h0;
                     init_busy_q <= 1'b1;
                     flag_space_select_n <= 1'b1;
                     state_q <= S_INIT;
                  end
                  else
                  begin
                     // claim writes zero first, release writes one
                     state_q <= S_WRITE;
                     read_write_n <= 1'b0;
                     data_out <= (cmd_op == `CMD_CLAIM) ? 8'h00 : 8'hff;
                     data_oe <= 1'b1;
                  end
               end
            end
            S_WRITE:
            begin
               // address and data hold for the whole strobe; the data drive is released with it and the address holds
               if (cnt_zero)
               begin
                  read_write_n <= 1'b1;
                  data_oe <= 1'b0;
                  flag_space_select_n <= 1'b1;
                  cnt_q <= RECOVER_CYC[7:0];
                  state_q <= S_GAP;
               end
               else
                  cnt_q <= cnt_q - 8'h01;
            end
            S_GAP:
            begin
               // selects stay high a while so the next read latches afresh
               if (!cnt_zero)
                  cnt_q <= cnt_q - 8'h01;
               else if (op_q == `CMD_CLAIM)
               begin
                  // read back after the write, never before
                  flag_space_select_n <= 1'b0;
                  output_enable_n <= 1'b0;
                  cnt_q <= ACCESS_CYC[7:0] + 8'h02;
                  state_q <= S_READ;
               end
               else if (op_q == `CMD_INIT && idx_q != 3'h7)
               begin
                  // next flag of the sweep
                  idx_q <= idx_q + 3'h1;
                  state_q <= S_INIT;
               end
               else
               begin
                  // the sweep is over once the last flag has had its release
                  if (op_q == `CMD_INIT)
                     init_busy_q <= 1'b0;
                  // a release gives the token up, so we no longer hold it
                  if (op_q == `CMD_RELEASE)
                     granted_q <= 1'b0;
                  state_q <= S_DONE;
               end
            end
            S_READ:
            begin
               // extra cycles cover the input synchroniser
               if (cnt_zero)
               begin
                  // every data bit carries the flag, so bit zero alone is enough
                  granted_q <= ~read_bit;
                  output_enable_n <= 1'b1;
                  flag_space_select_n <= 1'b1;
                  cnt_q <= RECOVER_CYC[7:0];
                  op_q <= `CMD_POLL;
                  state_q <= S_GAP;
               end
               else
                  cnt_q <= cnt_q - 8'h01;
            end
            S_DONE:
            begin
               // one-cycle completion; the next command may be taken on the following edge
               done_q <= 1'b1;
               state_q <= S_IDLE;
            end
            // a corrupt state code returns to idle instead of locking the port
            default:
               state_q <= S_IDLE;
         endcase
      end
   end
endmodule // flag_ctl

/* File: flag_ctl_defs.vh */
`ifndef FLAG_CTL_DEFS_VH
`define FLAG_CTL_DEFS_VH
// pin access timing, in ref_clk cycles (25 MHz, 40 ns)
`define ACCESS_NS 70
`define ACCESS_CYC ((`ACCESS_NS + 39) / 40)
`define RECOVER_NS 40
`define RECOVER_CYC ((`RECOVER_NS + 39) / 40)
`define FLAG_COUNT 8
`define INDEX_W 3
`define DATA_W 8
// host commands
`define CMD_CLAIM 2'h0
`define CMD_RELEASE 2'h1
`define CMD_POLL 2'h2
`define CMD_INIT 2'h3
`endif

/* File: flag_ctl_chk.sv */
`timescale 1ns/1ps
`include "flag_ctl_defs.vh"
module flag_ctl_chk #(parameter ADDR_W = 13)(
   input wire ref_clk,
   input wire resetn,
   input wire cmd_valid,
   input wire cmd_ready,
   input wire [1:0] cmd_op,
   input wire init_busy_q,
   input wire flag_space_select_n,
   input wire mem_select_n,
   input wire read_write_n,
   input wire output_enable_n,
   input wire [ADDR_W-1:0] addr,
   input wire data_oe
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   sequence s_claim; cmd_valid && cmd_ready && cmd_op == `CMD_CLAIM; endsequence
   sequence s_wr; !flag_space_select_n && !read_write_n; endsequence
   sequence s_rd; !flag_space_select_n && !output_enable_n; endsequence
   a_write_then_read: assert property (s_claim |-> ##[1:2] s_wr ##[1:12] s_rd)
      else $error("claim order");
   a_addr_low_only: assert property (addr[ADDR_W-1:3] == 0)
      else $error("high address bit");
   a_memory_unused: assert property (mem_select_n)
      else $error("memory select");
   a_write_drives: assert property (s_wr |-> data_oe)
      else $error("write undriven");
   a_read_released: assert property (!output_enable_n |-> read_write_n && !data_oe)
      else $error("read contention");
   a_poll_gap: assert property ($rose(output_enable_n) |=> output_enable_n)
      else $error("no enable gap");
   a_init_sweep: assert property ($rose(resetn) |-> init_busy_q)
      else $error("no init sweep");
   a_idle_standby: assert property (cmd_ready && !init_busy_q |-> flag_space_select_n && output_enable_n)
      else $error("not standby");
endmodule // flag_ctl_chk
bind flag_ctl flag_ctl_chk #(.ADDR_W(ADDR_W)) u_flag_ctl_chk(.*);

/* File: flag_dev_model.sv */
`timescale 1ns/1ps
module flag_dev_model(
   input wire flag_space_select_n,
   input wire read_write_n,
   input wire output_enable_n,
   input wire [12:0] addr,
   input wire [7:0] data_out,
   output wire [7:0] q
);
   reg [7:0] lreq = 8'h00, rreq = 8'h00, lown = 8'h00, rown = 8'h00;
   reg [7:0] hold = 8'hff;
   wire wr_en = !flag_space_select_n && !read_write_n;
   // a write lands as its strobe ends; address and data still stand on that edge
   always @(negedge wr_en) if (^{addr[2:0], data_out[0]} !== 1'bx) req(1'b1, addr[2:0], data_out[0]);
   // latched so a far-side write cannot change a read in flight
   always @(negedge flag_space_select_n or negedge output_enable_n)
   begin
      // let the address launched on the same edge settle first
      #1;
      if (!flag_space_select_n && !output_enable_n) hold = {8{!lown[addr[2:0]]}};
   end
   // a released bus shows the inverse so a stale value never passes
   assign q = !flag_space_select_n && !output_enable_n && read_write_n ? hold : ~hold;
   task req(input s, input [2:0] i, input v);
      begin
         if (s) lreq[i] = !v;
         else rreq[i] = !v;
         if (!v && !lown[i] && !rown[i])
         begin
            lown[i] = s;
            rown[i] = !s;
         end
         else if (v && (s ? lown[i] : rown[i]))
         begin
            lown[i] = !s && lreq[i];
            rown[i] = s && rreq[i];
         end
      end
   endtask
endmodule // flag_dev_model

/* File: flag_ctl_test.sv */
`timescale 1ns/1ps
`include "flag_ctl_defs.vh"
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin errors++; $display("wrong value %s %h %h", n, e, g); end end
module flag_ctl_test;
   reg ref_clk = 1'b0, resetn = 1'b0, cmd_valid = 1'b0;
   reg [1:0] cmd_op = 2'h0;
   reg [2:0] cmd_index = 3'h0;
   wire cmd_ready, done_q, granted_q, init_busy_q, flag_space_select_n, mem_select_n, read_write_n;
   wire output_enable_n, data_oe;
   wire [12:0] addr;
   wire [7:0] data_out, q;
   wire [7:0] data_in = data_oe ? data_out : q;
   int errors = 0, tests_run = 0;
   always #20 ref_clk = ~ref_clk;
   flag_ctl u_flag_ctl(.*);
   flag_dev_model u_flag_dev_model(.*);
   task complete_run;
      begin
         $display("checks %0d mismatches %0d", tests_run, errors);
         if (errors == 0 && tests_run > 0)
            $display("Run complete: PASS");
         else
            $display("Run complete: FAIL");
         $finish;
      end
   endtask
   task cmd(input [1:0] op, input [2:0] i);
      int n;
      begin
         cmd_op = op;
         cmd_index = i;
         cmd_valid = 1'b1;
         for (n = 0; n < 200 && cmd_ready !== 1'b1; n++) @(negedge ref_clk);
         if (cmd_ready !== 1'b1)
         begin
            errors++;
            complete_run;
         end
         @(negedge ref_clk) cmd_valid = 1'b0;
         for (n = 0; n < 200 && done_q !== 1'b1; n++) @(negedge ref_clk);
         if (done_q !== 1'b1)
         begin
            errors++;
            complete_run;
         end
         @(negedge ref_clk);
      end
   endtask
   task t_own;
      begin
         cmd(`CMD_CLAIM, 3'h5);
         `CHK("grant", 1'b1, granted_q)
         `CHK("owner", 2'b10, {u_flag_dev_model.lown[5], u_flag_dev_model.rown[5]})
         cmd(`CMD_RELEASE, 3'h5);
         `CHK("owner", 2'b00, {u_flag_dev_model.lown[5], u_flag_dev_model.rown[5]})
         `CHK("grant", 1'b0, granted_q)
         $display("t_own done");
      end
   endtask
   task t_pending;
      begin
         u_flag_dev_model.req(1'b0, 3'h2, 1'b0);
         cmd(`CMD_CLAIM, 3'h2);
         `CHK("grant", 1'b0, granted_q)
         `CHK("request", 1'b1, u_flag_dev_model.lreq[2])
         u_flag_dev_model.req(1'b0, 3'h2, 1'b1);
         cmd(`CMD_POLL, 3'h2);
         `CHK("grant", 1'b1, granted_q)
         cmd(`CMD_RELEASE, 3'h2);
         $display("t_pending done");
      end
   endtask
   task t_init;
      begin
         cmd(`CMD_CLAIM, 3'h7);
         cmd(`CMD_INIT, 3'h0);
         `CHK("owned", 8'h00, u_flag_dev_model.lown)
         `CHK("init busy", 1'b0, init_busy_q)
         $display("t_init done");
      end
   endtask
   initial
   begin
      repeat (4) @(negedge ref_clk);
      resetn = 1'b1;
      t_own;
      t_pending;
      t_init;
      complete_run;
   end
endmodule // flag_ctl_test
